// ==== pag_consts.vh ====
// pag_consts.vh: offsets, field positions, reset values and timing for the aggregation register block
// assumes a 50 MHz aclk and 32-bit AXI4-Lite register access
`ifndef PAG_CONSTS_VH
`define PAG_CONSTS_VH
`define PAG_OFF_CTRL          12'h000
`define PAG_OFF_AVAIL         12'h004
`define PAG_OFF_AGGR          12'h008
`define PAG_OFF_LINK          12'h00c
`define PAG_OFF_DISC          12'h010
`define PAG_OFF_STATUS        12'h01c
`define PAG_OFF_PARAM         12'h018
`define PAG_CTRL_SUBTYPE_BIT  0
`define PAG_CTRL_MULTI_BIT    1
`define PAG_ST_LINKEN_BIT     0
`define PAG_ST_IDLE_BIT       1
`define PAG_ST_MAPOK_BIT      2
`define PAG_PAR_TDB_BIT       1
`define PAG_PAR_DISC_BIT      0
`define PAG_PAR_AGG_BIT       2
`define PAG_CTRL_RST          2'h0
`define PAG_DISC_RST          48'h000000000000
`define PAG_TIMEOUT_S         30
`define PAG_CLK_HZ            50000000
`define PAG_TIMEOUT_CYC       (`PAG_TIMEOUT_S * `PAG_CLK_HZ)
`define PAG_RESP_OKAY         2'h0
`define PAG_RESP_SLVERR       2'h2
`endif

// ==== pag_idle_timer.v ====
// pag_idle_timer.v: counts uninterrupted idle cycles, pulses when the limit is reached
// assumes idle comes from logic on aclk
module pag_idle_timer #(
  parameter LIMIT = 1500000000,
  parameter W     = 31
) (
  input  wire aclk,    // clock
  input  wire aresetn, // sync reset, active low
  input  wire idle,    // idle condition level
  output reg  expire   // one-cycle pulse at limit
);
  reg [W-1:0] cnt_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r  <= {W{1'b0}};
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (!idle) begin
        cnt_r <= {W{1'b0}};
      end else if (cnt_r == LIMIT[W-1:0] - 1'b1) begin
        cnt_r  <= cnt_r + 1'b1;
        expire <= 1'b1;
      end else if (cnt_r < LIMIT[W-1:0]) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule // pag_idle_timer

// ==== pag_regs.v ====
// pag_regs.v: aggregation register bank with AXI4-Lite slave and remote atomic access port
// assumes remote access strobes come from PMA logic on aclk; pins go through two flops
`include "pag_consts.vh"
module pag_regs #(
  parameter NPME    = 8,
  parameter TIMEOUT = `PAG_TIMEOUT_CYC
) (
  input  wire            aclk,            // 50 MHz clock
  input  wire            aresetn,         // sync reset, active low
  input  wire [11:0]     s_axi_awaddr,    // write address
  input  wire            s_axi_awvalid,   // write address valid
  output wire            s_axi_awready,   // write address ready
  input  wire [31:0]     s_axi_wdata,     // write data
  input  wire [3:0]      s_axi_wstrb,     // write strobes
  input  wire            s_axi_wvalid,    // write data valid
  output wire            s_axi_wready,    // write data ready
  output reg  [1:0]      s_axi_bresp,     // write response
  output reg             s_axi_bvalid,    // write response valid
  input  wire            s_axi_bready,    // write response ready
  input  wire [11:0]     s_axi_araddr,    // read address
  input  wire            s_axi_arvalid,   // read address valid
  output wire            s_axi_arready,   // read address ready
  output reg  [31:0]     s_axi_rdata,     // read data
  output reg  [1:0]      s_axi_rresp,     // read response
  output reg             s_axi_rvalid,    // read data valid
  input  wire            s_axi_rready,    // read data ready
  input  wire            rem_req,         // remote access request, rising edge starts access
  input  wire            rem_wr,          // remote access is write
  input  wire [11:0]     rem_addr,        // remote access address
  input  wire [31:0]     rem_wdata,       // remote write data
  output reg  [31:0]     rem_rdata,       // remote read data
  output reg             rem_ack,         // remote access done pulse
  input  wire [NPME-1:0] link_state,      // per-entity link up, from pins
  output reg  [NPME-1:0] pmd_link_en,     // per-entity link enable
  output reg  [7:0]      standard_parameter_bit // advertised parameter bits
);
  localparam TW = 31;

  reg            rq_s1_r, rq_s2_r, rq_s3_r;
  reg [NPME-1:0] lk_s1_r, lk_s2_r;
  reg [1:0]      ctrl_r;
  reg [NPME-1:0] avail_r, aggr_r;
  reg [47:0]     disc_r;
  reg            aw_hold_r, w_hold_r;
  reg [11:0]     aw_addr_r;
  reg [31:0]     w_data_r;
  reg [3:0]      w_strb_r;
  wire           customer_side_subtype = ctrl_r[`PAG_CTRL_SUBTYPE_BIT];
  wire           multi_ok = ctrl_r[`PAG_CTRL_MULTI_BIT];
  wire           idle = ((lk_s2_r & aggr_r) == {NPME{1'b0}});
  wire           expire;
  wire           map_ok;
  wire           rem_go = rq_s2_r & ~rq_s3_r;
  wire           axi_wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  wire           wr_go;
  wire [11:0]    wr_addr;
  wire [31:0]    wr_data;
  wire [3:0]     wr_strb;

  // remote access wins the write port; a pending bus write simply waits one cycle
  assign wr_go   = (rem_go & rem_wr) | axi_wr_go;
  assign wr_addr = (rem_go & rem_wr) ? rem_addr : aw_addr_r;
  assign wr_data = (rem_go & rem_wr) ? rem_wdata : w_data_r;
  assign wr_strb = (rem_go & rem_wr) ? 4'hf : w_strb_r;

  function onehot;
    input [NPME-1:0] v;
    integer i;
    reg [7:0] n;
    begin
      n = 8'h00;
      for (i = 0; i < NPME; i = i + 1)
        n = n + {7'h00, v[i]};
      onehot = (n == 8'h01);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (st[b]) merge[b*8 +: 8] = nw[b*8 +: 8];
    end
  endfunction

  // merged images of each writable register but the low discovery word, cut to its width where stored
  wire [31:0]    ctrl_m  = merge({30'h0, ctrl_r}, wr_data, wr_strb);
  wire [31:0]    avail_m = merge({{(32-NPME){1'b0}}, avail_r}, wr_data, wr_strb);
  wire [31:0]    aggr_m  = merge({{(32-NPME){1'b0}}, aggr_r}, wr_data, wr_strb);
  wire [31:0]    dhi_m   = merge({16'h0, disc_r[47:32]}, wr_data, wr_strb);

  function [31:0] rd_mux;
    input [11:0] a;
    begin
      case (a)
        `PAG_OFF_CTRL:   rd_mux = {30'h0, ctrl_r};
        `PAG_OFF_AVAIL:  rd_mux = {{(32-NPME){1'b0}}, avail_r};
        `PAG_OFF_AGGR:   rd_mux = {{(32-NPME){1'b0}}, aggr_r};
        `PAG_OFF_LINK:   rd_mux = {{(32-NPME){1'b0}}, lk_s2_r};
        `PAG_OFF_DISC:   rd_mux = disc_r[31:0];
        `PAG_OFF_DISC + 12'h004: rd_mux = {16'h0, disc_r[47:32]};
        `PAG_OFF_STATUS: rd_mux = {29'h0, map_ok, idle, |pmd_link_en};
        `PAG_OFF_PARAM:  rd_mux = {24'h0, standard_parameter_bit};
        default:         rd_mux = 32'h0;
      endcase
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `PAG_OFF_CTRL) || (a == `PAG_OFF_AVAIL) || (a == `PAG_OFF_AGGR) ||
               (a == `PAG_OFF_LINK) || (a == `PAG_OFF_DISC) || (a == `PAG_OFF_DISC + 12'h004) ||
               (a == `PAG_OFF_STATUS) || (a == `PAG_OFF_PARAM);
    end
  endfunction

  // a single-entity device must show one availability bit; a multi device needs at least one
  assign map_ok = multi_ok ? (avail_r != {NPME{1'b0}}) : onehot(avail_r);

  pag_idle_timer #(.LIMIT(TIMEOUT), .W(TW)) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .idle    (idle),
    .expire  (expire)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      rq_s1_r <= 1'b0;
      rq_s2_r <= 1'b0;
      rq_s3_r <= 1'b0;
      lk_s1_r <= {NPME{1'b0}};
      lk_s2_r <= {NPME{1'b0}};
    end else begin
      rq_s1_r <= rem_req;
      rq_s2_r <= rq_s1_r;
      rq_s3_r <= rq_s2_r;
      lk_s1_r <= link_state;
      lk_s2_r <= lk_s1_r;
    end
  end

  // register writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r  <= `PAG_CTRL_RST;
      avail_r <= {{(NPME-1){1'b0}}, 1'b1};
      aggr_r  <= {NPME{1'b0}};
      disc_r  <= `PAG_DISC_RST;
    end else begin
      if (wr_go) begin
        case (wr_addr)
          `PAG_OFF_CTRL:  ctrl_r  <= ctrl_m[1:0];
          `PAG_OFF_AVAIL: begin
            // single-entity unit refuses a map that is not one-hot; clearing the
            // multi bit later does not trim an existing map, software rewrites it
            if (multi_ok || onehot(avail_m[NPME-1:0]))
              avail_r <= avail_m[NPME-1:0];
          end
          `PAG_OFF_AGGR:  aggr_r  <= aggr_m[NPME-1:0];
          `PAG_OFF_DISC:  disc_r[31:0] <= merge(disc_r[31:0], wr_data, wr_strb);
          `PAG_OFF_DISC + 12'h004: disc_r[47:32] <= dhi_m[15:0];
          default: ;
        endcase
      end
      // timeout clear wins over a same-cycle write
      if (expire)
        disc_r <= `PAG_DISC_RST;
    end
  end

  // link enables and advertised parameter bits
  always @(posedge aclk) begin
    if (!aresetn) begin
      pmd_link_en            <= {NPME{1'b0}};
      standard_parameter_bit <= 8'h00;
    end else begin
      pmd_link_en <= (customer_side_subtype && !onehot(avail_r)) ? {NPME{1'b0}} : avail_r;
      standard_parameter_bit <= 8'h00;
      standard_parameter_bit[`PAG_PAR_DISC_BIT] <= |avail_r;
      standard_parameter_bit[`PAG_PAR_AGG_BIT]  <= |avail_r;
      standard_parameter_bit[`PAG_PAR_TDB_BIT]  <= 1'b0;
    end
  end

  // remote atomic access: whole-word, one cycle, no bus interleave
  always @(posedge aclk) begin
    if (!aresetn) begin
      rem_ack   <= 1'b0;
      rem_rdata <= 32'h0;
    end else begin
      rem_ack <= rem_go;
      if (rem_go && !rem_wr)
        rem_rdata <= rd_mux(rem_addr);
    end
  end

  // axi write channel
  assign s_axi_awready = ~aw_hold_r;
  assign s_axi_wready  = ~w_hold_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      aw_addr_r    <= 12'h0;
      w_data_r     <= 32'h0;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PAG_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_hold_r) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && !w_hold_r) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (axi_wr_go && !(rem_go && rem_wr)) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_r) ? `PAG_RESP_OKAY : `PAG_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read channel
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `PAG_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux({s_axi_araddr[11:2], 2'b00});
      s_axi_rresp  <= mapped({s_axi_araddr[11:2], 2'b00}) ? `PAG_RESP_OKAY : `PAG_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // pag_regs

// ==== pag_regs_props.sv ====
// pag_regs_props.sv: port-level timing checks for the aggregation register bank
// assumes it is bound to every pag_regs instance
module pag_regs_props #(
  parameter int NPME = 8
) (
  input wire logic            aclk,                  // clock
  input wire logic            aresetn,               // sync reset, active low
  input wire logic            s_axi_arvalid,         // read address valid
  input wire logic            s_axi_arready,         // read address ready
  input wire logic            s_axi_rvalid,          // read data valid
  input wire logic            s_axi_bvalid,          // write response valid
  input wire logic            s_axi_bready,          // write response ready
  input wire logic            rem_req,               // remote request
  input wire logic            rem_ack,               // remote done
  input wire logic [NPME-1:0] pmd_link_en,           // link enables
  input wire logic [7:0]      standard_parameter_bit // advertised bits
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rem_go;
    $rose(rem_req);
  endsequence
  sequence s_rem_done;
    ##[1:5] rem_ack;
  endsequence
  a_bonding_flag_low: assert property (standard_parameter_bit[1] == 1'b0)
    else $error("bonding flag advertised");
  a_remote_ack_due: assert property (s_rem_go |-> s_rem_done)
    else $error("remote access not acknowledged");
  a_remote_ack_pulse: assert property (rem_ack |=> !rem_ack)
    else $error("remote ack longer than one cycle");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  a_write_resp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  // reset must also silence the links, so gating starts from off
  a_reset_links_off: assert property (disable iff (1'b0) !aresetn |=> pmd_link_en == '0 && !rem_ack)
    else $error("outputs active after reset");
endmodule // pag_regs_props
bind pag_regs pag_regs_props #(.NPME(NPME)) u_props (.*);

// ==== pag_remote_model.sv ====
// pag_remote_model.sv: remote phy issuing atomic register accesses
// assumes the bench calls access and the block acks on aclk
module pag_remote_model (
  input  wire logic        aclk,      // clock
  output logic             rem_req,   // request level
  output logic             rem_wr,    // write flag
  output logic [11:0]      rem_addr,  // address
  output logic [31:0]      rem_wdata, // write data
  input  wire logic        rem_ack,   // done pulse
  input  wire logic [31:0] rem_rdata  // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {rem_req, rem_wr, rem_addr, rem_wdata} = '0;
  task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge aclk);
    {rem_req, rem_wr, rem_addr, rem_wdata} <= {1'b1, w, a, d};
    do @(posedge aclk); while (rem_ack !== 1'b1);
    q = rem_rdata;
    // stale lines scrambled so a late sample cannot pass by luck
    {rem_req, rem_wr, rem_addr, rem_wdata} <= {1'b0, ~w, ~a, ~d};
    repeat (3) @(posedge aclk);
  endtask
endmodule // pag_remote_model

// ==== tb_top.sv ====
// tb_top.sv: self-checking bench for the aggregation register bank
// assumes pag_consts.vh on the include path; idle limit shortened to 20 cycles
`include "pag_consts.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, s;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0, rem_addr;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rem_wdata, rem_rdata, q, v;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rem_req, rem_wr, rem_ack;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [7:0]  link_state = 0, pmd_link_en, standard_parameter_bit;
  int          fails = 0, check_count = 0, seed = 13716;
  always #10 aclk = ~aclk;
  pag_regs #(.NPME(8), .TIMEOUT(20)) uut (.*);
  pag_remote_model rm (.*);
  function automatic logic [7:0] exp_en(logic sub, logic [7:0] m);
    return (sub && $countones(m) != 1) ? 8'h00 : m;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, `PAG_RESP_OKAY)
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    q = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic stop_test;
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PAG_OFF_AVAIL); `CHK($countones(q), 1)
    `CHK(standard_parameter_bit[`PAG_PAR_TDB_BIT], 1'b0)
    wr(`PAG_OFF_PARAM, '1); rd(`PAG_OFF_PARAM); `CHK(q[`PAG_PAR_TDB_BIT], 1'b0)
    `CHK(q, 32'h5)
    rd(`PAG_OFF_STATUS); `CHK(q, 32'h7)
    wr(`PAG_OFF_AVAIL, 32'h6); rd(`PAG_OFF_AVAIL); `CHK(q, 32'h1)
    rd(12'h100); `CHK({rr, q}, {`PAG_RESP_SLVERR, 32'h0})
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      // corners first: two bits, then none, both on a customer-side unit
      if (i < 2) v[8:0] = i ? 9'h100 : 9'h106;
      s = v[8];
      wr(`PAG_OFF_CTRL, {30'h0, 1'b1, s});
      wr(`PAG_OFF_AVAIL, {24'h0, v[7:0]});
      repeat (4) @(posedge aclk);
      `CHK(pmd_link_en, exp_en(s, v[7:0]))
    end
    wr(`PAG_OFF_AGGR, 32'h1);
    link_state <= 8'h01;
    v = $random(seed) | 32'h1;
    rm.access(1'b1, `PAG_OFF_DISC, v, q); rd(`PAG_OFF_DISC); `CHK(q, v)
    rm.access(1'b0, `PAG_OFF_AGGR, '0, q); `CHK(q[7:0], 8'h01)
    repeat (40) @(posedge aclk);
    rd(`PAG_OFF_DISC); `CHK(q, v)
    link_state <= 8'h02;
    repeat (12) @(posedge aclk);
    link_state <= 8'h01;
    repeat (5) @(posedge aclk);
    link_state <= 8'h02;
    repeat (12) @(posedge aclk);
    rd(`PAG_OFF_DISC); `CHK(q, v)
    repeat (20) @(posedge aclk);
    rd(`PAG_OFF_DISC); `CHK(q, 32'h0)
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    fails++;
    stop_test;
  end
endmodule // tb_top
